// file: acc_pkg.sv
// Purpose: Shared constants and types for the accelerometer sample and mode block
// Assumes: 100 MHz system clock, byte-wide register map reached over I2C
// Notes: Register map, field positions, reset values and cycle counts live here
package acc_pkg;
   // Register map
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_OUT_X_MSB = 8'h01;
   localparam logic [7:0] REG_OUT_X_LSB = 8'h02;
   localparam logic [7:0] REG_OUT_Y_MSB = 8'h03;
   localparam logic [7:0] REG_OUT_Y_LSB = 8'h04;
   localparam logic [7:0] REG_OUT_Z_MSB = 8'h05;
   localparam logic [7:0] REG_OUT_Z_LSB = 8'h06;
   localparam logic [7:0] REG_FIFO_SETUP = 8'h09;
   localparam logic [7:0] REG_XYZ_CFG = 8'h0E;
   localparam logic [7:0] REG_CTRL1 = 8'h2A;
   localparam logic [7:0] REG_OFF_BASE = 8'h2F;
   // Field positions
   localparam int CTRL1_ACTIVE = 0;
   localparam int CTRL1_FREAD = 1;
   // Reset values
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] FSETUP_RST = 8'h00;
   localparam logic [7:0] XYZCFG_RST = 8'h00;
   localparam logic [7:0] OFF_RST = 8'h00;
   // Sizes and timing
   localparam int NUM_OFF = 6;
   localparam int FIFO_DEPTH = 32;
   localparam int SYS_CLK_MHZ = 100;
   localparam int TRIM_LOAD_NS = 1000;
   localparam int TRIM_LOAD_CYC = (TRIM_LOAD_NS * SYS_CLK_MHZ + 999) / 1000;
   localparam int GAIN_UNITY = 1024;
   localparam int GAIN_SHIFT = 10;
   // FIFO modes as held in fifo_setup[7:6]
   typedef enum logic [1:0] {
      FM_OFF = 2'h0, FM_CIRC = 2'h1, FM_FILL = 2'h2, FM_TRIG = 2'h3
   } acc_fmode_e;
   typedef enum logic [2:0] {
      PM_STANDBY = 3'b001, PM_WAKE = 3'b010, PM_SLEEP = 3'b100
   } acc_pmode_e;
   typedef enum logic [4:0] {
      I_IDLE = 5'b00001, I_ADDR = 5'b00010, I_PTR = 5'b00100, I_WR = 5'b01000, I_RD = 5'b10000
   } acc_i2c_e;
   // Raw front-end sample, 4096 counts/g, per axis
   typedef struct packed {
      logic [2:0][15:0] axis;
   } acc_raw_s;
   // Formatted 14-bit sample, per axis
   typedef struct packed {
      logic [2:0][13:0] axis;
   } acc_smp_s;
   // Factory trim word: per-axis gain and offset, signed
   typedef struct packed {
      logic [2:0][7:0] gain;
      logic [2:0][7:0] offset;
   } acc_trim_s;
endpackage

// file: acc_sample_fifo_mode_ctrl.sv
// Purpose: Sample formatting, 32-entry FIFO and standby/active control behind an I2C slave
// Assumes: SCL/SDA are open drain pins; front end delivers samples on its own clock
// Notes: FIFO modes, fast read and standby/active retention as listed below
// Overview of operation
// - Run bit clear keeps standby: registers reachable, analog and sample clock off
// - Run bit set enters active with analog enabled, registers still reachable
// - Going from active to standby leaves every register untouched
// - Going from standby to active clears FIFO state and output data
// - Sleep and wake sample states exist only inside active
// - Trim values are fetched after reset before any sample is used
// - Six volatile host offset registers shift each axis zero point
// - Each axis is a signed 14-bit value split over high and low bytes
// - The high byte holds the upper eight bits of the sample
// - Fast-read bit set lets host read just the three high bytes
// - Fast-read bit clear means full 14-bit register walk
// - Output and FIFO work in every full-scale range
// - At 2g one count is 1/4096 g, range -2g to +1.99975g
// - At 8g one count is 1/1024 g, range -8g to +7.999g
// - The 8-bit result is 64 times coarser than the 14-bit result
// - FIFO holds 32 samples per axis at any data rate
// - FIFO may be read as full 14-bit or high byte only
// - FIFO modes fill, circular, trigger, disabled come from fifo_setup
// - Fill mode keeps first 32, flags overflow, stops until read
// - Circular mode overwrites the oldest so the newest 32 remain
// - Trigger mode keeps history then a set number of post-event samples
// - Watermark from 1 to 32 signals the host when reached
`timescale 1ns/1ps
module acc_sample_fifo_mode_ctrl #(
   parameter logic [6:0] DEV_ADDR = 7'h1D,
   parameter int DEPTH = acc_pkg::FIFO_DEPTH
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic adc_clk_i,
   input wire logic adc_valid_i,
   input wire acc_pkg::acc_raw_s adc_sample_i,
   input wire acc_pkg::acc_trim_s trim_storage_i,
   input wire logic sleep_req_i,
   input wire logic fifo_trigger_i,
   output logic analog_en_o,
   output acc_pkg::acc_pmode_e power_mode_o,
   output logic fifo_wm_o,
   output logic fifo_ovf_o
);
   localparam logic [5:0] DEPTH_C = 6'(DEPTH);

   logic [1:0] adc_rst_q;
   logic adc_tgl_r;
   acc_pkg::acc_raw_s adc_hold_r;
   logic [2:0] tgl_q;
   logic [2:0] scl_q;
   logic [2:0] sda_q;
   logic [7:0] ctrl1_r;
   logic [7:0] fifo_setup_r;
   logic [7:0] xyz_cfg_r;
   logic [7:0] uoff_r [acc_pkg::NUM_OFF];
   acc_pkg::acc_pmode_e pmode_r;
   logic start_evt;
   logic [7:0] trim_cnt_r;
   logic trim_done_r;
   acc_pkg::acc_trim_s trim_r;
   acc_pkg::acc_smp_s conv;
   acc_pkg::acc_smp_s smp_new_r;
   logic smp_vld_r;
   logic smp_ok;
   logic [1:0] fs_sh;
   acc_pkg::acc_smp_s mem [DEPTH];
   logic [4:0] wptr_r;
   logic [4:0] rptr_r;
   logic [5:0] fcnt_r;
   logic ovf_r;
   logic trig_hit_r;
   logic [5:0] post_left_r;
   acc_pkg::acc_fmode_e fmode;
   logic [5:0] wmark;
   logic full;
   logic pop;
   logic store;
   logic drop;
   logic ovf_set;
   acc_pkg::acc_smp_s head;
   acc_pkg::acc_i2c_e ist_r;
   logic [3:0] bcnt_r;
   logic [7:0] sh_r;
   logic ackph_r;
   logic mack_r;
   logic [7:0] ptr_r;
   logic sda_oe_r;
   logic wr_stb_r;
   logic [7:0] wr_addr_r;
   logic [7:0] wr_data_r;
   logic pop_req_r;
   logic [7:0] rdata;
   logic fread;
   logic scl_rise;
   logic scl_fall;
   logic i2c_start;
   logic i2c_stop;

   // Saturate a wide signed value to 14 bits
   function automatic logic [13:0] sat14(input logic signed [19:0] v);
      if (v > 20'sh01FFF) begin
         return 14'h1FFF;
      end else if (v < -20'sh02000) begin
         return 14'h2000;
      end
      return v[13:0];
   endfunction

   // Register pointer advance; fast read hops over the low bytes
   function automatic logic [7:0] nxt_ptr(input logic [7:0] p, input logic fr);
      if (fr && (p == acc_pkg::REG_OUT_Z_MSB)) begin
         return acc_pkg::REG_STATUS;
      end else if (fr && ((p == acc_pkg::REG_OUT_X_MSB) || (p == acc_pkg::REG_OUT_Y_MSB))) begin
         return p + 8'h02;
      end
      return p + 8'h01;
   endfunction

   // Front-end domain: reset level crosses on two flops, sample held, event toggled
   always_ff @(posedge adc_clk_i) begin
      adc_rst_q <= {adc_rst_q[0], rst_n_i};
   end

   always_ff @(posedge adc_clk_i) begin
      if (!adc_rst_q[1]) begin
         adc_tgl_r <= 1'b0;
      end else if (adc_valid_i) begin
         adc_hold_r <= adc_sample_i; // Stable long before the toggle is seen
         adc_tgl_r <= ~adc_tgl_r;
      end
   end

   // Pin and toggle synchronisers; stage 0 feeds stage 1 only
   always_ff @(posedge sys_clk_i) begin
      tgl_q <= {tgl_q[1:0], adc_tgl_r};
      scl_q <= {scl_q[1:0], scl_i};
      sda_q <= {sda_q[1:0], sda_i};
   end

   assign scl_rise = scl_q[1] & ~scl_q[2];
   assign scl_fall = ~scl_q[1] & scl_q[2];
   assign i2c_start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
   assign i2c_stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];

   // Power mode; sleep and wake only below active
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         pmode_r <= acc_pkg::PM_STANDBY;
      end else if (!ctrl1_r[acc_pkg::CTRL1_ACTIVE]) begin
         pmode_r <= acc_pkg::PM_STANDBY;
      end else if (sleep_req_i) begin
         pmode_r <= acc_pkg::PM_SLEEP;
      end else begin
         pmode_r <= acc_pkg::PM_WAKE;
      end
   end

   // First cycle of active; only volatile FIFO and output state is cleared
   assign start_evt = (pmode_r == acc_pkg::PM_STANDBY) && ctrl1_r[acc_pkg::CTRL1_ACTIVE];

   // Trim fetch after reset release; storage port is a static fuse word
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         trim_cnt_r <= 8'h00;
         trim_done_r <= 1'b0;
         trim_r <= '0;
      end else if (!trim_done_r) begin
         trim_cnt_r <= trim_cnt_r + 8'h01;
         if (trim_cnt_r == 8'(acc_pkg::TRIM_LOAD_CYC - 1)) begin
            trim_r <= trim_storage_i;
            trim_done_r <= 1'b1;
         end
      end
   end

   // Range select: 2g keeps 4096 counts/g, 4g halves, 8g quarters
   assign fs_sh = (xyz_cfg_r[1:0] == 2'h3) ? 2'h2 : xyz_cfg_r[1:0];

   // Per-axis gain trim, factory offset, range scaling, user offset, saturation
   for (genvar a = 0; a < 3; a++) begin : g_axis
      logic signed [27:0] prod;
      logic signed [19:0] base;
      logic signed [19:0] tot;
      logic [13:0] uoff;
      assign prod = $signed(adc_hold_r.axis[a]) * ($signed(12'(acc_pkg::GAIN_UNITY))
                    + $signed({{4{trim_r.gain[a][7]}}, trim_r.gain[a]}));
      assign base = $signed({{2{prod[27]}}, prod[27:acc_pkg::GAIN_SHIFT]})
                    + $signed({{12{trim_r.offset[a][7]}}, trim_r.offset[a]});
      assign uoff = {uoff_r[2 * a], uoff_r[2 * a + 1][7:2]};
      assign tot = (base >>> fs_sh) + $signed({{6{uoff[13]}}, uoff});
      assign conv.axis[a] = sat14(tot);
   end

   assign smp_ok = trim_done_r && (pmode_r != acc_pkg::PM_STANDBY);

   // Latest sample, taken on each crossed front-end event while running
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || start_evt) begin
         smp_new_r <= '0;
         smp_vld_r <= 1'b0;
      end else begin
         smp_vld_r <= (tgl_q[2] ^ tgl_q[1]) && smp_ok;
         if ((tgl_q[2] ^ tgl_q[1]) && smp_ok) begin
            smp_new_r <= conv;
         end
      end
   end

   // FIFO control decode
   assign fmode = acc_pkg::acc_fmode_e'(fifo_setup_r[7:6]);
   assign wmark = fifo_setup_r[5:0];
   assign full = (fcnt_r == DEPTH_C);
   assign pop = pop_req_r && (fcnt_r != 6'h00) && (fmode != acc_pkg::FM_OFF);

   always_comb begin
      store = 1'b0;
      drop = 1'b0;
      ovf_set = 1'b0;
      if (smp_vld_r) begin
         unique case (fmode)
            acc_pkg::FM_OFF: begin
               store = 1'b0;
            end
            acc_pkg::FM_FILL: begin
               if (full && !pop) begin
                  ovf_set = 1'b1;
               end else begin
                  store = 1'b1;
               end
            end
            acc_pkg::FM_CIRC: begin
               store = 1'b1;
               drop = full && !pop;
               ovf_set = full && !pop;
            end
            acc_pkg::FM_TRIG: begin
               if (!trig_hit_r || (post_left_r != 6'h00)) begin
                  store = 1'b1;
                  drop = full && !pop;
                  ovf_set = full && !pop;
               end
            end
         endcase
      end
   end

   // Sample storage; data only, pointers carry the state
   always_ff @(posedge sys_clk_i) begin
      if (store) begin
         mem[wptr_r] <= smp_new_r;
      end
   end

   // Pointers, fill count and overflow; overflow set beats the read clear
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || start_evt || (fmode == acc_pkg::FM_OFF)) begin
         wptr_r <= 5'h00;
         rptr_r <= 5'h00;
         fcnt_r <= 6'h00;
         ovf_r <= 1'b0;
      end else begin
         wptr_r <= wptr_r + 5'(store);
         rptr_r <= rptr_r + 5'(pop | drop);
         fcnt_r <= fcnt_r + 6'(store) - 6'(pop) - 6'(drop);
         if (ovf_set) begin
            ovf_r <= 1'b1;
         end else if (pop) begin
            ovf_r <= 1'b0;
         end
      end
   end

   // Trigger capture; post-event sample budget comes from the watermark field
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || start_evt || (fmode != acc_pkg::FM_TRIG)) begin
         trig_hit_r <= 1'b0;
         post_left_r <= 6'h00;
      end else if (!trig_hit_r && fifo_trigger_i && smp_ok) begin
         trig_hit_r <= 1'b1;
         post_left_r <= wmark;
      end else if (trig_hit_r && store && (post_left_r != 6'h00)) begin
         post_left_r <= post_left_r - 6'h01;
      end
   end

   // Output data: FIFO head when buffering, else latest sample
   assign head = (fmode == acc_pkg::FM_OFF) ? smp_new_r : ((fcnt_r == 6'h00) ? '0 : mem[rptr_r]);
   assign fread = ctrl1_r[acc_pkg::CTRL1_FREAD];

   // Register read mux; low bytes keep the six fraction bits left aligned
   always_comb begin
      rdata = 8'h00;
      if ((ptr_r >= acc_pkg::REG_OFF_BASE) && (ptr_r < acc_pkg::REG_OFF_BASE + 8'(acc_pkg::NUM_OFF))) begin
         rdata = uoff_r[3'(ptr_r - acc_pkg::REG_OFF_BASE)];
      end
      case (ptr_r)
         acc_pkg::REG_STATUS: rdata = {ovf_r, fifo_wm_o, fcnt_r};
         acc_pkg::REG_OUT_X_MSB: rdata = head.axis[0][13:6];
         acc_pkg::REG_OUT_X_LSB: rdata = {head.axis[0][5:0], 2'h0};
         acc_pkg::REG_OUT_Y_MSB: rdata = head.axis[1][13:6];
         acc_pkg::REG_OUT_Y_LSB: rdata = {head.axis[1][5:0], 2'h0};
         acc_pkg::REG_OUT_Z_MSB: rdata = head.axis[2][13:6];
         acc_pkg::REG_OUT_Z_LSB: rdata = {head.axis[2][5:0], 2'h0};
         acc_pkg::REG_FIFO_SETUP: rdata = fifo_setup_r;
         acc_pkg::REG_XYZ_CFG: rdata = xyz_cfg_r;
         acc_pkg::REG_CTRL1: rdata = ctrl1_r;
         default: ;
      endcase
   end

   // I2C slave: 7-bit address, pointer byte, auto-increment on data bytes
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ist_r <= acc_pkg::I_IDLE;
         bcnt_r <= 4'h0;
         sh_r <= 8'h00;
         ackph_r <= 1'b0;
         mack_r <= 1'b1;
         ptr_r <= 8'h00;
         sda_oe_r <= 1'b0;
         wr_stb_r <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
         pop_req_r <= 1'b0;
      end else begin
         wr_stb_r <= 1'b0;
         pop_req_r <= 1'b0;
         if (i2c_stop) begin
            ist_r <= acc_pkg::I_IDLE;
            sda_oe_r <= 1'b0;
         end else if (i2c_start) begin
            ist_r <= acc_pkg::I_ADDR;
            bcnt_r <= 4'h0;
            ackph_r <= 1'b0;
            sda_oe_r <= 1'b0;
         end else if (scl_rise && (ist_r != acc_pkg::I_IDLE)) begin
            if (ackph_r) begin
               mack_r <= sda_q[1];
            end else begin
               bcnt_r <= bcnt_r + 4'h1;
               if (ist_r != acc_pkg::I_RD) begin
                  sh_r <= {sh_r[6:0], sda_q[1]};
               end
            end
         end else if (scl_fall && (ist_r != acc_pkg::I_IDLE)) begin
            if (ackph_r) begin
               // End of acknowledge slot; a read continues only on master ack
               ackph_r <= 1'b0;
               bcnt_r <= 4'h0;
               sda_oe_r <= 1'b0;
               if (ist_r == acc_pkg::I_RD) begin
                  if (!mack_r) begin
                     sh_r <= rdata;
                     sda_oe_r <= ~rdata[7];
                     ptr_r <= nxt_ptr(ptr_r, fread);
                     pop_req_r <= (ptr_r == (fread ? acc_pkg::REG_OUT_Z_MSB : acc_pkg::REG_OUT_Z_LSB));
                  end else begin
                     ist_r <= acc_pkg::I_IDLE;
                  end
               end
            end else if (bcnt_r == 4'h8) begin
               ackph_r <= 1'b1;
               case (ist_r)
                  acc_pkg::I_ADDR: begin
                     if (sh_r[7:1] == DEV_ADDR) begin
                        sda_oe_r <= 1'b1;
                        ist_r <= sh_r[0] ? acc_pkg::I_RD : acc_pkg::I_PTR;
                     end else begin
                        ist_r <= acc_pkg::I_IDLE;
                     end
                  end
                  acc_pkg::I_PTR: begin
                     ptr_r <= sh_r;
                     sda_oe_r <= 1'b1;
                     ist_r <= acc_pkg::I_WR;
                  end
                  acc_pkg::I_WR: begin
                     wr_stb_r <= 1'b1;
                     wr_addr_r <= ptr_r;
                     wr_data_r <= sh_r;
                     ptr_r <= nxt_ptr(ptr_r, fread);
                     sda_oe_r <= 1'b1;
                  end
                  default: begin
                     sda_oe_r <= 1'b0; // Master drives its acknowledge
                  end
               endcase
            end else if (ist_r == acc_pkg::I_RD) begin
               sh_r <= {sh_r[6:0], 1'b0};
               sda_oe_r <= ~sh_r[6];
            end
         end
      end
   end

   // Control and configuration; standby entry leaves them as written
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ctrl1_r <= acc_pkg::CTRL1_RST;
         fifo_setup_r <= acc_pkg::FSETUP_RST;
         xyz_cfg_r <= acc_pkg::XYZCFG_RST;
      end else if (wr_stb_r) begin
         if (wr_addr_r == acc_pkg::REG_CTRL1) begin
            ctrl1_r <= wr_data_r;
         end
         if (wr_addr_r == acc_pkg::REG_FIFO_SETUP) begin
            fifo_setup_r <= wr_data_r;
         end
         if (wr_addr_r == acc_pkg::REG_XYZ_CFG) begin
            xyz_cfg_r <= wr_data_r;
         end
      end
   end

   // Six volatile user offset registers
   for (genvar i = 0; i < acc_pkg::NUM_OFF; i++) begin : g_off
      always_ff @(posedge sys_clk_i) begin
         if (!rst_n_i) begin
            uoff_r[i] <= acc_pkg::OFF_RST;
         end else if (wr_stb_r && (wr_addr_r == acc_pkg::REG_OFF_BASE + 8'(i))) begin
            uoff_r[i] <= wr_data_r;
         end
      end
   end

   // Registered outputs; SDA only ever pulls low
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         analog_en_o <= 1'b0;
         power_mode_o <= acc_pkg::PM_STANDBY;
         fifo_wm_o <= 1'b0;
         fifo_ovf_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
         sda_oe_o <= sda_oe_r;
         analog_en_o <= (pmode_r != acc_pkg::PM_STANDBY);
         power_mode_o <= pmode_r;
         fifo_wm_o <= (fmode != acc_pkg::FM_OFF) && (wmark != 6'h00) && (fcnt_r >= wmark);
         fifo_ovf_o <= ovf_r;
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   a_standby_analog_off: assert property ((pmode_r == acc_pkg::PM_STANDBY) |=> !analog_en_o)
      else $error("analog on in standby");
   a_active_analog_on: assert property ((pmode_r != acc_pkg::PM_STANDBY) |=> analog_en_o)
      else $error("analog off while active");
   a_stop_keeps_fifo: assert property ($fell(ctrl1_r[0]) |=> $stable(fcnt_r) && $stable(fifo_setup_r))
      else $error("state lost entering standby");
   a_start_clears_fifo: assert property (start_evt |=> (fcnt_r == 6'h00) && !ovf_r)
      else $error("FIFO not cleared on wake");
   // Mode register lags the run bit by one cycle, so a clear while asleep is legal this cycle
   a_sleep_in_active: assert property ((pmode_r == acc_pkg::PM_SLEEP) |-> $past(ctrl1_r[0]))
      else $error("sleep outside active");
   a_no_pretrim_sample: assert property (!trim_done_r |-> ##1 !smp_vld_r)
      else $error("sample before trim load");
   a_fill_overflow: assert property ((fmode == acc_pkg::FM_FILL) && smp_vld_r && full && !pop_req_r
                                     |=> ovf_r && (fcnt_r == 6'h20))
      else $error("fill mode overflow wrong");
   a_circ_stays_full: assert property ((fmode == acc_pkg::FM_CIRC) && smp_vld_r && full
                                       |=> (fcnt_r >= 6'h1F) && (fmode != acc_pkg::FM_CIRC || fcnt_r != 6'h00))
      else $error("circular mode lost depth");
   a_off_stores_none: assert property ((fmode == acc_pkg::FM_OFF) |=> (fcnt_r == 6'h00) ##1 !fifo_ovf_o)
      else $error("disabled FIFO holds data");
   a_watermark_flag: assert property ((fmode != acc_pkg::FM_OFF) && (wmark != 6'h00) && (fcnt_r >= wmark)
                                      |=> fifo_wm_o)
      else $error("watermark not signalled");
endmodule

// file: acc_i2c_host_model.sv
// Purpose: Host processor model that bit-bangs the two-wire register bus
// Assumes: SDA has a pull-up, so a released line reads high
// Notes: Phases last 6 clocks, above the 4-clock minimum of the slave
`timescale 1ns/1ps
module acc_i2c_host_model (
   input wire logic clk_i,
   input wire logic sda_oe_i,
   output logic scl_o,
   output logic sda_o
);
   logic host_oe = 1'b0;
   int nacks = 0;
   initial scl_o = 1'b1;
   // Wired-AND of both pull-downs against the pull-up
   assign sda_o = ~(host_oe | sda_oe_i);
   task hp;
      repeat (6) @(posedge clk_i);
   endtask
   // Data moves only while SCL is low, so no false start or stop is seen
   task clk_bit(input logic low, output logic seen);
      host_oe <= low;
      hp;
      scl_o <= 1'b1;
      hp;
      seen = sda_o;
      scl_o <= 1'b0;
      hp;
   endtask
   task start;
      host_oe <= 1'b0;
      hp;
      scl_o <= 1'b1;
      hp;
      host_oe <= 1'b1;
      hp;
      scl_o <= 1'b0;
      hp;
   endtask
   task stop;
      host_oe <= 1'b1;
      hp;
      scl_o <= 1'b1;
      hp;
      host_oe <= 1'b0;
      hp;
   endtask
   task tx(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(~d[i], s);
      clk_bit(1'b0, s);
      if (s !== 1'b0) nacks++;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      start;
      tx({7'h1D, 1'b0});
      tx(a);
      tx(d);
      stop;
   endtask
   // Every byte but the last is acked; the last is refused so the slave lets go of SDA
   task rd(input logic [7:0] a, input int n, output logic [23:0] d);
      logic s;
      logic t;
      start;
      tx({7'h1D, 1'b0});
      tx(a);
      start;
      tx({7'h1D, 1'b1});
      for (int b = n - 1; b >= 0; b--) begin
         for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b0, t);
            d[8 * b + i] = t;
         end
         clk_bit(b != 0, s);
      end
      stop;
   endtask
endmodule

// file: tb_acc_sample_fifo_mode_ctrl.sv
// Purpose: Self-checking bench for modes, sample format, fast read and FIFO modes
// Assumes: Trim words are zero, so samples pass through unscaled at 2g
// Notes: Link clock is gated off outside sample bursts, as in standby
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_acc_sample_fifo_mode_ctrl;
   logic sys_clk = 0, rst_n = 0, adc_ck = 0, adc_run = 1, adc_valid = 0, sleep_req = 0;
   logic scl, sda_w, sda_oe, analog_en, wm, ovf, sda_drv;
   logic [23:0] rb;
   acc_pkg::acc_raw_s smp = '0;
   acc_pkg::acc_pmode_e pm;
   int err_total = 0, n_compared = 0;
   wire adc_clk = adc_ck & adc_run;
   always #5 sys_clk = ~sys_clk;
   initial begin
      #3;
      forever #24 adc_ck = ~adc_ck;
   end
   acc_i2c_host_model u_acc_i2c_host_model (.clk_i(sys_clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda_w));
   acc_sample_fifo_mode_ctrl u_acc_sample_fifo_mode_ctrl (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_drv), .sda_oe_o(sda_oe), .adc_clk_i(adc_clk), .adc_valid_i(adc_valid),
      .adc_sample_i(smp), .trim_storage_i('0), .sleep_req_i(sleep_req), .fifo_trigger_i(1'b0),
      .analog_en_o(analog_en), .power_mode_o(pm), .fifo_wm_o(wm), .fifo_ovf_o(ovf));
   task test_done;
      if (err_total == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk_reg(input logic [7:0] a, input logic [7:0] e);
      u_acc_i2c_host_model.rd(a, 1, rb);
      `CHK("reg", e, rb[7:0])
   endtask
   // A mode that never arrives ends the run at once
   task wait_pm(input acc_pkg::acc_pmode_e e);
      for (int k = 0; k < 50 && pm !== e; k++) @(posedge sys_clk);
      `CHK("mode", e, pm)
      if (pm !== e) test_done;
   endtask
   // One three-axis sample, then enough link edges to cross domains
   task push(input logic [15:0] v);
      @(negedge adc_ck) adc_run = 1'b1;
      @(posedge adc_clk) adc_valid <= 1'b1;
      smp <= {3{v}};
      @(posedge adc_clk) adc_valid <= 1'b0;
      repeat (4) @(posedge adc_clk);
      @(negedge adc_ck) adc_run = 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask
   task t_modes;
      `CHK("analog", 1'b0, analog_en)
      push(16'h0123);
      u_acc_i2c_host_model.wr(acc_pkg::REG_CTRL1, 8'h01);
      wait_pm(acc_pkg::PM_WAKE);
      `CHK("analog", 1'b1, analog_en)
      chk_reg(acc_pkg::REG_OUT_X_MSB, 8'h00);
      sleep_req <= 1'b1;
      wait_pm(acc_pkg::PM_SLEEP);
      sleep_req <= 1'b0;
      wait_pm(acc_pkg::PM_WAKE);
   endtask
   task t_format;
      push(16'h0123);
      chk_reg(acc_pkg::REG_OUT_X_MSB, 8'h04);
      chk_reg(acc_pkg::REG_OUT_X_LSB, 8'h8C);
      push(16'hE000);
      chk_reg(acc_pkg::REG_OUT_Z_MSB, 8'h80);
      u_acc_i2c_host_model.wr(acc_pkg::REG_OFF_BASE + 8'h01, 8'h04);
      push(16'h0123);
      chk_reg(acc_pkg::REG_OUT_X_LSB, 8'h90);
      u_acc_i2c_host_model.wr(acc_pkg::REG_XYZ_CFG, 8'h02);
      push(16'h0123);
      chk_reg(acc_pkg::REG_OUT_X_LSB, 8'h24);
      u_acc_i2c_host_model.wr(acc_pkg::REG_XYZ_CFG, 8'h00);
      u_acc_i2c_host_model.wr(acc_pkg::REG_OFF_BASE + 8'h01, 8'h00);
   endtask
   // Watermark 32: flag at 32, overflow on the 33rd; fill keeps the oldest, circular drops it
   task t_fifo(input logic [7:0] setup, input logic [7:0] oldest);
      u_acc_i2c_host_model.wr(acc_pkg::REG_FIFO_SETUP, 8'h00);
      u_acc_i2c_host_model.wr(acc_pkg::REG_FIFO_SETUP, setup);
      chk_reg(acc_pkg::REG_FIFO_SETUP, setup);
      for (int i = 1; i <= 33; i++) begin
         push(16'(i * 64));
         if (i == 31) `CHK("wm", 1'b0, wm)
         if (i == 32) `CHK("ovf", 1'b0, ovf)
      end
      `CHK("ovf", 1'b1, ovf)
      `CHK("wm", 1'b1, wm)
      chk_reg(acc_pkg::REG_STATUS, 8'hE0);
      chk_reg(acc_pkg::REG_OUT_X_MSB, oldest);
   endtask
   task t_keep;
      u_acc_i2c_host_model.wr(acc_pkg::REG_CTRL1, 8'h00);
      wait_pm(acc_pkg::PM_STANDBY);
      chk_reg(acc_pkg::REG_FIFO_SETUP, 8'hA0);
      chk_reg(acc_pkg::REG_STATUS, 8'hE0);
      u_acc_i2c_host_model.wr(acc_pkg::REG_CTRL1, 8'h01);
      wait_pm(acc_pkg::PM_WAKE);
      chk_reg(acc_pkg::REG_STATUS, 8'h00);
      chk_reg(8'h7F, 8'h00);
      `CHK("nack", 0, u_acc_i2c_host_model.nacks)
      `CHK("sda_o", 1'b0, sda_drv)
   endtask
   // Fast read walks the three high bytes and pops once; cleared, the walk is full
   task t_fast;
      push(16'h0123);
      u_acc_i2c_host_model.wr(acc_pkg::REG_CTRL1, 8'h03);
      u_acc_i2c_host_model.rd(acc_pkg::REG_OUT_X_MSB, 3, rb);
      `CHK("fast", 24'h040404, rb)
      chk_reg(acc_pkg::REG_STATUS, 8'h00);
      u_acc_i2c_host_model.wr(acc_pkg::REG_CTRL1, 8'h01);
      push(16'h0123);
      u_acc_i2c_host_model.rd(acc_pkg::REG_OUT_X_MSB, 2, rb);
      `CHK("full", 16'h048C, rb[15:0])
   endtask
   // Reset spans 8 link cycles so the slower domain sees it too
   initial begin
      repeat (8) @(posedge adc_ck);
      @(negedge adc_ck) adc_run = 1'b0;
      @(posedge sys_clk) rst_n <= 1'b1;
      repeat (110) @(posedge sys_clk);
      t_modes;
      t_format;
      t_fifo(8'h60, 8'h02);
      t_fifo(8'hA0, 8'h01);
      t_keep;
      t_fast;
      test_done;
   end
endmodule
